// ---- common/mdio_access_defines.vh ----
// Register map, field layout and timing constants of the PHY access engine
`ifndef MDIO_ACCESS_DEFINES_VH
`define MDIO_ACCESS_DEFINES_VH

// APB register byte offsets
`define OFS_ACCESS0      12'h000
`define OFS_ACCESS1      12'h004
`define OFS_CONTROL      12'h008
`define OFS_RAW          12'h00c
`define OFS_MASKED       12'h010
`define OFS_MASK_SET     12'h014
`define OFS_MASK_CLR     12'h018
`define OFS_RESPONDED    12'h01c

// user_access_reg fields
`define UA_GO            31
`define UA_WRITE         30
`define UA_ACK           29
`define UA_REG_HI        25
`define UA_REG_LO        21
`define UA_PHY_HI        20
`define UA_PHY_LO        16
`define UA_DATA_HI       15
`define UA_DATA_LO       0
// Bits software may write: go, write, reg, phy, data
`define UA_WR_MASK       32'hc3ffffff

// Control register fields
`define CTL_ENABLE       30
`define CTL_PREAMBLE_OFF 20
`define CTL_DIV_HI       15
`define CTL_DIV_LO       0
`define CTL_DIV_RESET    16'h00ff

// Frame layout, counted in bit slots
`define PRE_BITS         6'd32
`define FRAME_BITS       6'd32
`define TA_FIRST_BIT     6'd14
`define TA_SECOND_BIT    6'd15
`define DATA_FIRST_BIT   6'd16

// Frame header constants
`define SOF_CODE         2'b01
`define OP_WRITE         2'b01
`define OP_READ          2'b10
`define TA_WRITE         2'b10

`endif

// ---- logic/pin_sync.v ----
// Two-flop synchroniser for one external level
`timescale 1ns/100ps
module pin_sync (
	input  wire i_clk_sys,
	input  wire i_rst,
	input  wire i_async,
	output wire o_sync
);
	reg meta_reg;
	reg sync_reg;

	// First stage feeds only the second stage
	always @(posedge i_clk_sys) begin
		if (i_rst) begin
			meta_reg <= 1'b1;
			sync_reg <= 1'b1;
		end else begin
			meta_reg <= i_async;
			sync_reg <= meta_reg;
		end
	end

	assign o_sync = sync_reg;
endmodule // pin_sync

// ---- logic/mdc_divider.v ----
// Management clock divider producing clock level and edge strobes
`timescale 1ns/100ps
`include "mdio_access_defines.vh"
module mdc_divider (
	input  wire        i_clk_sys,
	input  wire        i_rst,
	input  wire        i_run,
	input  wire [15:0] i_div,
	output reg         o_mdc,
	output reg         o_rise,
	output reg         o_fall
);
	reg [15:0] count_reg;

	// Half period is div+1 system clocks; idle clock rests low
	always @(posedge i_clk_sys) begin
		if (i_rst || !i_run) begin
			count_reg <= 16'h0000;
			o_mdc     <= 1'b0;
			o_rise    <= 1'b0;
			o_fall    <= 1'b0;
		end else if (count_reg >= i_div) begin
			count_reg <= 16'h0000;
			o_mdc     <= ~o_mdc;
			o_rise    <= ~o_mdc;
			o_fall    <= o_mdc;
		end else begin
			count_reg <= count_reg + 16'h0001;
			o_rise    <= 1'b0;
			o_fall    <= 1'b0;
		end
	end
endmodule // mdc_divider

// ---- logic/mdio_user_phy_access.v ----
// PHY register access engine with APB registers and management bus master
//
// Summary of operation
// - One write with go starts a read
// - Read data lands in issuing slot
// - Completion clears go; ack shows PHY answer
// - Completion sets raw bit of that slot
// - Unmasked completion sets masked bit, interrupts
// - One write with go and write starts write
// - Pending slots served round robin
// - User reads update responded map
`timescale 1ns/100ps
`include "mdio_access_defines.vh"
module mdio_user_phy_access (
	input  wire        i_clk_sys,
	input  wire        i_rst,
	input  wire        i_psel,
	input  wire        i_penable,
	input  wire        i_pwrite,
	input  wire [11:0] i_paddr,
	input  wire [31:0] i_pwdata,
	output reg  [31:0] o_prdata,
	output reg         o_pready,
	output reg         o_pslverr,
	output reg         o_mdc,
	output reg         o_mdio_out,
	output reg         o_mdio_oe,
	input  wire        i_mdio_in,
	output reg         o_irq
);
	// One-hot engine states
	localparam ST_IDLE = 4'b0001;
	localparam ST_PRE  = 4'b0010;
	localparam ST_SHIFT = 4'b0100;
	localparam ST_DONE = 4'b1000;

	// Register file and engine state
	reg [31:0] access_reg [0:1];
	reg [31:0] control_reg;
	reg [1:0]  raw_reg;
	reg [1:0]  mask_reg;
	reg [31:0] responded_reg;
	reg [3:0]  state_reg;
	reg        slot_reg;
	reg        last_reg;
	reg [5:0]  bit_reg;
	reg [31:0] shift_reg;
	reg [15:0] rdata_reg;
	reg        ack_reg;
	reg        write_op_reg;

	// Decodes, strobes and divider outputs
	wire       mdio_sync;
	wire       mdc_lvl;
	wire       mdc_rise;
	wire       mdc_fall;
	wire       setup;
	wire       wr_acc;
	wire [1:0] pend;
	wire       pick;
	wire       busy;
	wire       done_evt;
	wire       wr_access0;
	wire       wr_access1;
	wire       wr_control;
	wire       wr_mask_set;
	wire       wr_mask_clr;
	wire       wr_raw;
	wire [4:0] done_phy;
	reg  [31:0] rd_mux;

	// Address match helper shared by all register decodes
	function hit;
		input [11:0] addr;
		input [11:0] ofs;
		begin
			hit = (addr == ofs);
		end
	endfunction

	// Frame header for the chosen slot: sof, opcode, phy, reg, ta, data
	function [31:0] frame_word;
		input [31:0] ua;
		begin
			frame_word = {`SOF_CODE,
				ua[`UA_WRITE] ? `OP_WRITE : `OP_READ,
				ua[`UA_PHY_HI:`UA_PHY_LO], ua[`UA_REG_HI:`UA_REG_LO],
				`TA_WRITE, ua[`UA_DATA_HI:`UA_DATA_LO]};
		end
	endfunction

	// Line from the PHY crosses into the system clock here
	pin_sync u_sync (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_async   (i_mdio_in),
		.o_sync    (mdio_sync)
	);

	// Clock runs only while a frame is in flight
	mdc_divider u_div (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_run     (busy),
		.i_div     (control_reg[`CTL_DIV_HI:`CTL_DIV_LO]),
		.o_mdc     (mdc_lvl),
		.o_rise    (mdc_rise),
		.o_fall    (mdc_fall)
	);

	// APB decode; single-cycle answer
	assign setup  = i_psel && !i_penable;
	assign wr_acc = i_psel && i_penable && i_pwrite;
	assign pend   = {access_reg[1][`UA_GO], access_reg[0][`UA_GO]};
	// Alternate after last served slot when both wait
	assign pick   = (pend == 2'b11) ? ~last_reg : pend[1];
	assign busy   = (state_reg == ST_PRE) || (state_reg == ST_SHIFT);
	assign done_evt = (state_reg == ST_DONE);

	// Write strobes, one per writable register, valid at the access edge only
	assign wr_access0  = wr_acc && o_pready && hit(i_paddr, `OFS_ACCESS0);
	assign wr_access1  = wr_acc && o_pready && hit(i_paddr, `OFS_ACCESS1);
	assign wr_control  = wr_acc && o_pready && hit(i_paddr, `OFS_CONTROL);
	assign wr_mask_set = wr_acc && o_pready && hit(i_paddr, `OFS_MASK_SET);
	assign wr_mask_clr = wr_acc && o_pready && hit(i_paddr, `OFS_MASK_CLR);
	assign wr_raw      = wr_acc && o_pready && hit(i_paddr, `OFS_RAW);

	// PHY address of the frame being retired
	assign done_phy = access_reg[slot_reg][`UA_PHY_HI:`UA_PHY_LO];

	// Read data mux
	always @* begin
		// Unmapped addresses read as zero
		rd_mux = 32'h00000000;
		if (hit(i_paddr, `OFS_ACCESS0))
			rd_mux = access_reg[0];
		else if (hit(i_paddr, `OFS_ACCESS1))
			rd_mux = access_reg[1];
		else if (hit(i_paddr, `OFS_CONTROL))
			rd_mux = control_reg;
		else if (hit(i_paddr, `OFS_RAW))
			rd_mux = {30'h00000000, raw_reg};
		else if (hit(i_paddr, `OFS_MASKED))
			rd_mux = {30'h00000000, raw_reg & mask_reg};
		// Mask set and clear both read back the mask
		else if (hit(i_paddr, `OFS_MASK_SET) || hit(i_paddr, `OFS_MASK_CLR))
			rd_mux = {30'h00000000, mask_reg};
		else if (hit(i_paddr, `OFS_RESPONDED))
			rd_mux = responded_reg;
	end

	// APB answer registers; addresses above the responded register return slverr
	// Read data follows the setup address, so it stands with ready
	always @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_pready  <= 1'b0;
			o_prdata  <= 32'h00000000;
			o_pslverr <= 1'b0;
		end else begin
			o_pready  <= setup;
			o_prdata  <= rd_mux;
			o_pslverr <= setup && (i_paddr > `OFS_RESPONDED);
		end
	end

	// Control, mask and raw status; hardware set wins over clear
	always @(posedge i_clk_sys) begin
		if (i_rst) begin
			control_reg <= {16'h0000, `CTL_DIV_RESET};
			mask_reg    <= 2'b00;
			raw_reg     <= 2'b00;
		end else begin
			if (wr_control)
				control_reg <= i_pwdata;
			if (wr_mask_set)
				mask_reg <= mask_reg | i_pwdata[1:0];
			else if (wr_mask_clr)
				mask_reg <= mask_reg & ~i_pwdata[1:0];
			// Set wins, so a completion is never lost to a clear
			if (done_evt)
				raw_reg <= (raw_reg & ~(wr_raw ? i_pwdata[1:0] : 2'b00))
					| (slot_reg ? 2'b10 : 2'b01);
			else if (wr_raw)
				raw_reg <= raw_reg & ~i_pwdata[1:0];
		end
	end

	// Access slots: software writes only while idle; engine completes
	always @(posedge i_clk_sys) begin
		if (i_rst) begin
			access_reg[0] <= 32'h00000000;
			access_reg[1] <= 32'h00000000;
		end else begin
			// A slot with go set refuses software writes until done
			if (wr_access0 && !access_reg[0][`UA_GO])
				access_reg[0] <= i_pwdata & `UA_WR_MASK;
			if (wr_access1 && !access_reg[1][`UA_GO])
				access_reg[1] <= i_pwdata & `UA_WR_MASK;
			// Ack only means something for reads; writes leave it clear
			if (done_evt) begin
				access_reg[slot_reg][`UA_GO] <= 1'b0;
				access_reg[slot_reg][`UA_ACK] <= !write_op_reg && ack_reg;
				// Write frames keep the data software gave
				if (!write_op_reg)
					access_reg[slot_reg][`UA_DATA_HI:`UA_DATA_LO]
						<= rdata_reg;
			end
		end
	end

	// Frame engine: preamble, header, turnaround, data
	always @(posedge i_clk_sys) begin
		if (i_rst) begin
			state_reg    <= ST_IDLE;
			slot_reg     <= 1'b0;
			last_reg     <= 1'b1;
			bit_reg      <= 6'd0;
			shift_reg    <= 32'h00000000;
			rdata_reg    <= 16'h0000;
			ack_reg      <= 1'b0;
			write_op_reg <= 1'b0;
			responded_reg <= 32'h00000000;
		end else begin
			case (state_reg)
			ST_IDLE: begin
				// Requests wait here while the engine is disabled
				if (control_reg[`CTL_ENABLE] && (pend != 2'b00)) begin
					slot_reg     <= pick;
					write_op_reg <= access_reg[pick][`UA_WRITE];
					shift_reg    <= frame_word(access_reg[pick]);
					bit_reg      <= 6'd0;
					ack_reg      <= 1'b0;
					state_reg    <= control_reg[`CTL_PREAMBLE_OFF] ?
						ST_SHIFT : ST_PRE;
				end
			end
			ST_PRE: begin
				// Preamble of ones, counted on falling edges
				if (mdc_fall) begin
					if (bit_reg == `PRE_BITS - 6'd1) begin
						bit_reg   <= 6'd0;
						state_reg <= ST_SHIFT;
					end else
						bit_reg <= bit_reg + 6'd1;
				end
			end
			ST_SHIFT: begin
				// PHY data sampled at rising management clock
				if (mdc_rise && !write_op_reg) begin
					if (bit_reg == `TA_SECOND_BIT)
						ack_reg <= !mdio_sync;
					else if (bit_reg >= `DATA_FIRST_BIT)
						rdata_reg <= {rdata_reg[14:0], mdio_sync};
				end
				// Next bit goes out after the fall, settled by the rise
				if (mdc_fall) begin
					shift_reg <= {shift_reg[30:0], 1'b0};
					if (bit_reg == `FRAME_BITS - 6'd1)
						state_reg <= ST_DONE;
					else
						bit_reg <= bit_reg + 6'd1;
				end
			end
			ST_DONE: begin
				// Results written back; served slot loses priority
				last_reg  <= slot_reg;
				state_reg <= ST_IDLE;
				if (!write_op_reg)
					responded_reg[done_phy] <= ack_reg;
			end
			default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// Pin drivers; the bus is released during read turnaround and data
	// Outputs are registered, so the pins lag the engine by one clock
	always @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_mdc      <= 1'b0;
			o_mdio_out <= 1'b1;
			o_mdio_oe  <= 1'b0;
		end else begin
			o_mdc      <= mdc_lvl;
			o_mdio_out <= (state_reg == ST_SHIFT) ? shift_reg[31] : 1'b1;
			o_mdio_oe  <= (state_reg == ST_PRE) ||
				((state_reg == ST_SHIFT) &&
				(write_op_reg || bit_reg < `TA_FIRST_BIT));
		end
	end

	// Level interrupt while any unmasked completion is pending
	// Registered, so irq trails the status bits by one clock
	always @(posedge i_clk_sys) begin
		if (i_rst)
			o_irq <= 1'b0;
		else
			o_irq <= |(raw_reg & mask_reg);
	end
endmodule // mdio_user_phy_access

// ---- sim/mdio_user_phy_access_checker.sv ----
// Port-level assertions for the PHY access engine
`timescale 1ns/100ps
module mdio_user_phy_access_checker (
	input wire        i_clk_sys,
	input wire        i_rst,
	input wire        i_psel,
	input wire        i_penable,
	input wire        i_pwrite,
	input wire [11:0] i_paddr,
	input wire [31:0] i_pwdata,
	input wire [31:0] o_prdata,
	input wire        o_pready,
	input wire        o_pslverr,
	input wire        o_mdc,
	input wire        o_mdio_out,
	input wire        o_mdio_oe,
	input wire        i_mdio_in,
	input wire        o_irq
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	// Bus answers with no wait states
	AST_PREADY_SETUP: assert property (i_psel && !i_penable |=> o_pready)
		else $error("no ready after setup");
	AST_PREADY_ONE: assert property (o_pready |=> !o_pready)
		else $error("ready held too long");
	AST_PREADY_ACC: assert property (o_pready |-> i_psel && i_penable)
		else $error("ready outside access");
	AST_SLVERR: assert property (o_pready |-> o_pslverr == (i_paddr > 12'h01c))
		else $error("wrong slave error");
	// Bench divider gives four clocks per half period
	AST_MDC_HOLD: assert property ($rose(o_mdc) |=> o_mdc [*3])
		else $error("clock high too short");
	AST_MDIO_LOW: assert property (o_mdio_oe && $past(o_mdio_oe)
		&& $changed(o_mdio_out) |-> !o_mdc)
		else $error("data moved while clock high");
	// Irq drops two clocks after the write edge: status, then irq register
	AST_IRQ_FALL: assert property ($fell(o_irq) |-> $past(i_penable && i_pwrite, 2))
		else $error("irq fell without write");
	AST_RST: assert property (disable iff (1'b0) i_rst |=> !o_irq && !o_mdio_oe && !o_mdc)
		else $error("outputs active in reset");
	cover property ($rose(o_irq));
	cover property (o_pready && o_pslverr);
	cover property ($fell(o_mdio_oe));
endmodule // mdio_user_phy_access_checker
bind mdio_user_phy_access mdio_user_phy_access_checker i_chk (.*);

// ---- sim/phy_model.sv ----
// Behavioural management-bus PHY with a 32-word register file
`timescale 1ns/100ps
module phy_model #(parameter logic [4:0] ADDR = 5'd3) (
	input  wire logic i_mdc,
	input  wire logic i_line,
	output logic      o_low
);
	logic [15:0] mem [32];
	logic [15:0] h;
	logic [4:0]  ra;
	int          n = 0;
	bit          rd, wr;
	initial begin
		o_low = 0;
		foreach (mem[i]) mem[i] = 16'h0000;
	end
	// Sample on rise, drive just after it; the pull-up covers release
	always @(posedge i_mdc) begin
		h = {h[14:0], i_line};
		if (n > 0 || !i_line) n++;
		if (n == 14) begin
			rd = h[11:10] == 2'b10 && h[9:5] == ADDR;
			wr = h[11:10] == 2'b01 && h[9:5] == ADDR;
			ra = h[4:0];
		end
		if (rd && n == 15) o_low = 1;
		if (rd && n > 15 && n < 32) o_low = !mem[ra][31-n];
		if (n == 32) begin
			if (wr) mem[ra] = h;
			o_low = 0;
			n = 0;
			rd = 0;
			wr = 0;
		end
	end
endmodule // phy_model

// ---- sim/mdio_user_phy_access_bench.sv ----
// Self-checking bench for the PHY access engine
`timescale 1ns/100ps
module mdio_user_phy_access_bench;
	localparam logic [4:0] PHY = 5'd3;
	logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, r;
	logic        pready, pslverr, mdc, mdio_out, oe, irq, low, err;
	logic [4:0]  g, p;
	logic [15:0] mem [32];
	logic [1:0]  msk = 2'b01;
	int          fail_count, tests_run, cyc;
	// Open-drain line with pull-up
	wire         line = oe ? mdio_out : !low;
	mdio_user_phy_access i_dut (.i_clk_sys(clk), .i_rst(rst), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .o_mdc(mdc), .o_mdio_out(mdio_out),
		.o_mdio_oe(oe), .i_mdio_in(line), .o_irq(irq));
	phy_model #(.ADDR(PHY)) i_phy (.i_mdc(mdc), .i_line(line), .o_low(low));
	always #10 clk = ~clk;
	// Hang guard, well above ten frames
	always @(posedge clk) if (++cyc == 40000) begin
		fail_count++;
		tally_and_finish;
	end
	task automatic apb(input bit w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task chk(input logic [31:0] gv, ev);
		tests_run++;
		if (gv !== ev) begin
			fail_count++;
			$display("[FAIL] %0t got %h exp %h", $time, gv, ev);
		end
	endtask
	task tally_and_finish;
		if (fail_count == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// One access on slot s, then readback, status and irq
	task automatic op(input int s, input bit w, input logic [15:0] d);
		logic        ack;
		logic [15:0] ed;
		apb(1, 12'(4*s), {1'b1, w, 4'h0, g, p, d});
		do apb(0, 12'(4*s), 0); while (r[31] !== 1'b0);
		ack = !w && p == PHY;
		ed = w ? d : (ack ? mem[g] : 16'hffff);
		if (w && p == PHY) mem[g] = d;
		chk(r, {1'b0, w, ack, 3'b000, g, p, ed});
		apb(0, 12'h00c, 0);
		chk(r, 32'(1 << s));
		chk({31'h0, irq}, {31'h0, msk[s]});
		apb(1, 12'h00c, 32'(1 << s));
		if (!w) begin
			apb(0, 12'h01c, 0);
			chk({31'h0, r[p]}, {31'h0, ack});
		end
	endtask
	initial begin
		void'($urandom(83));
		foreach (mem[i]) mem[i] = 0;
		repeat (12) @(posedge clk);
		rst <= 0;
		apb(0, 12'h008, 0);
		chk(r, 32'h000000ff);
		apb(0, 12'h020, 0);
		chk({31'h0, err}, 32'h1);
		// Enable with half period of four clocks: 160 ns link clock
		apb(1, 12'h008, 32'h40000003);
		apb(1, 12'h014, 32'h1);
		for (int i = 0; i < 4; i++) begin
			g = 5'($urandom);
			p = i < 3 ? PHY : 5'd17;
			op(i % 2, 1, 16'($urandom));
			op(i % 2, 0, 16'h0);
		end
		// Engine held off so both slots queue; busy slot drops a write
		apb(1, 12'h008, 32'h00000003);
		apb(1, 12'h000, {2'b11, 4'h0, 5'd1, PHY, 16'h1234});
		apb(1, 12'h004, {2'b10, 4'h0, 5'd1, PHY, 16'h0000});
		apb(1, 12'h000, {2'b11, 4'h0, 5'd1, PHY, 16'hbeef});
		// Slot 1 ran last, so slot 0 writes first and slot 1 reads it
		apb(1, 12'h008, 32'h40000003);
		do apb(0, 12'h004, 0); while (r[31] !== 1'b0);
		chk(r, {2'b00, 1'b1, 3'b000, 5'd1, PHY, 16'h1234});
		apb(0, 12'h000, 0);
		chk(r, {2'b01, 4'h0, 5'd1, PHY, 16'h1234});
		apb(0, 12'h00c, 0);
		chk(r, 32'h3);
		apb(0, 12'h010, 0);
		chk(r, 32'h1);
		apb(1, 12'h018, 32'h1);
		apb(0, 12'h010, 0);
		chk(r, 32'h0);
		chk({31'h0, irq}, 32'h0);
		tally_and_finish;
	end
endmodule // mdio_user_phy_access_bench
